/* inc/scf_pkg.sv */
// scf_pkg: shared constants and types for the 16-bit command frame link
// assumes: both ends run on clk_sys (10 MHz) and sample link pins synchronously
`default_nettype none
package scf_pkg;
    // ----------------------------------------------------------------
    // frame layout
    // ----------------------------------------------------------------
    localparam int FRAME_BITS     = 16;
    localparam int OP_HIGH_POS    = 15;
    localparam int OP_LOW_POS     = 14;
    localparam int INDEX_MSB      = 13;
    localparam int INDEX_LSB      = 9;
    localparam int PARITY_POS     = 8;
    localparam int PAYLOAD_MSB    = 7;
    localparam int STATUS_MSB     = 15;
    localparam int STATUS_LSB     = 8;
    localparam int INDEX_W        = 5;
    localparam int REG_COUNT      = 32;

    typedef enum logic [1:0] {
        OP_READ_CONTENT = 2'b00,
        OP_WRITE        = 2'b01,
        OP_RESERVED     = 2'b10,
        OP_READ_FLAGS   = 2'b11
    } scf_op_type;

    // ----------------------------------------------------------------
    // values after reset and fixed codes
    // ----------------------------------------------------------------
    localparam logic [7:0]  REG_RESET_VALUE = 8'h00;
    localparam logic [15:0] HARMLESS_READ   = 16'h2580;
    localparam logic [4:0]  LIN_REG_INDEX   = 5'h13;
    localparam logic [7:0]  LIN_TXRX_MASK   = 8'hC0;
    localparam logic [4:0]  EXT_STATUS_IDX  = 5'h00;

    // ----------------------------------------------------------------
    // timing at 10 MHz
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS      = 100;
    localparam int SELECT_LOW_NS      = 5500;
    localparam int SELECT_LOW_CYCLES  = (SELECT_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
    localparam int HALF_BIT_CYCLES    = 2;
endpackage : scf_pkg
`default_nettype wire

/* inc/scf_link_if.sv */
// scf_link_if: four-wire serial link between master end and device end
// assumes: single clock clk_sys; all pins synchronous to it
`default_nettype none
interface scf_link_if;
    logic selN;
    logic sclk;
    logic mosi;
    logic miso;

    modport master (
        output selN,
        output sclk,
        output mosi,
        input  miso
    );
    modport device (
        input  selN,
        input  sclk,
        input  mosi,
        output miso
    );
endinterface : scf_link_if
`default_nettype wire

/* logic/scf_device.sv */
// scf_device: device end of the 16-bit command frame link with register bank
// assumes: sclk, selN, mosi synchronous to clk_sys; mode 0 (sample on rising sclk)
`default_nettype none
//Function
// - one 16-bit frame, top bits select operation
// - bits 13..9 carry register index
// - bit 8 parity on write, next on read
// - bits 7..0 carry command payload
// - status byte out on bits 15..8
// - low byte: ext status, content or flags
// - no pass-through, no daisy chain
// - decode 00 read, 01 write, 11 flags
// - master sets bit 8 on reads
// - write bit 8 is parity value
// - master holds select low over 5.5 us
// - master follows writes with one read
// - unaccepted write completed by next frame
// - only writes may be delayed
// - lin txrx command needs lin transmit high
module scf_device (
    input  wire logic          clk_sys,
    input  wire logic          nrst,
    input  wire logic          clkEn,
    scf_link_if.device         link,
    input  wire logic [7:0]    fixedStatus,
    input  wire logic [7:0]    extStatus,
    input  wire logic [7:0]    flagsIn [scf_pkg::REG_COUNT],
    input  wire logic          parityEnable,
    input  wire logic          linTxd,
    input  wire logic          writeStall,
    output logic [7:0]         regContent [scf_pkg::REG_COUNT],
    output logic [4:0]         flagClearIdx,
    output logic               flagClear,
    output logic               parityError,
    output logic               linTxRxMode
);
    import scf_pkg::*;

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    // decode below is written for one 16-bit frame and a 5-bit index
    if (FRAME_BITS != 16) begin : gBadFrame
        $error("frame length must be sixteen bits");
    end
    if (REG_COUNT != (1 << INDEX_W)) begin : gBadBank
        $error("register count must match the index width");
    end
    if (INDEX_MSB - INDEX_LSB + 1 != INDEX_W) begin : gBadIndex
        $error("index field width mismatch");
    end
    if (STATUS_MSB - STATUS_LSB != 7) begin : gBadStatus
        $error("status field must be one byte");
    end

    // ----------------------------------------------------------------
    // link sampling
    // ----------------------------------------------------------------
    logic        sclkLast;
    logic        selLast;
    logic [15:0] shiftIn;
    logic [15:0] shiftOut;
    logic [4:0]  bitCount;
    logic        pendingValid;
    logic [15:0] pendingFrame;

    wire sclkRise  = link.sclk & ~sclkLast;
    wire sclkFall  = ~link.sclk & sclkLast;
    wire selFall   = ~link.selN & selLast;
    wire selRise   = link.selN & ~selLast;
    wire frameOk   = selRise && (bitCount == 5'(FRAME_BITS));

    wire scf_op_type op     = scf_op_type'(shiftIn[OP_HIGH_POS:OP_LOW_POS]);
    wire [4:0]  index       = shiftIn[INDEX_MSB:INDEX_LSB];
    wire        parityBit   = shiftIn[PARITY_POS];
    wire [7:0]  payload     = shiftIn[PAYLOAD_MSB:0];
    wire        calcParity  = ^{shiftIn[15:9], shiftIn[7:0]};
    wire        parityBad   = parityEnable && (calcParity != parityBit);

    // ----------------------------------------------------------------
    // frame decode
    // ----------------------------------------------------------------
    wire isWrite   = frameOk && (op == OP_WRITE);
    wire isFlagRd  = frameOk && (op == OP_READ_FLAGS);
    // a stalled write is parked and finished by the following good frame
    wire acceptNow = isWrite && !writeStall && !parityBad;
    wire parkNow   = isWrite && writeStall && !parityBad;
    wire flushPend = frameOk && pendingValid;

    // a parked frame takes the place of this frame's own write
    wire        applyWrite = flushPend || acceptNow;
    wire [4:0]  applyIdx   = flushPend ? pendingFrame[INDEX_MSB:INDEX_LSB] : index;
    wire [7:0]  applyData  = flushPend ? pendingFrame[PAYLOAD_MSB:0] : payload;
    wire        linReq     = applyWrite && (applyIdx == LIN_REG_INDEX)
                             && ((applyData & LIN_TXRX_MASK) == LIN_TXRX_MASK);
    wire        linBlocked = linReq && !linTxd;

    // response low byte picked by the incoming op and index; no mosi bypass
    logic [7:0] respByte;
    // used as the eighth bit arrives, so op and index sit in the seven lowest bits
    wire scf_op_type nextOp = scf_op_type'(shiftIn[6:5]);
    wire [4:0]  nextIdx     = shiftIn[4:0];

    always_comb begin
        unique case (nextOp)
            OP_READ_CONTENT: respByte = regContent[nextIdx];
            OP_READ_FLAGS:   respByte = flagsIn[nextIdx];
            default:         respByte = extStatus;
        endcase
    end

    // ----------------------------------------------------------------
    // shifter
    // ----------------------------------------------------------------
    // pin history reset to idle levels, so no false edge follows reset
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            sclkLast <= 1'b0;
            selLast  <= 1'b1;
        end else if (clkEn) begin
            sclkLast <= link.sclk;
            selLast  <= link.selN;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            shiftIn  <= 16'h0000;
            shiftOut <= 16'h0000;
            bitCount <= 5'h00;
        end else if (clkEn) begin
            if (selFall) begin
                shiftOut <= {fixedStatus, extStatus};
                bitCount <= 5'h00;
            end else if (!link.selN && sclkRise) begin
                shiftIn  <= {shiftIn[14:0], link.mosi};
                if (bitCount != 5'h1F)
                    bitCount <= bitCount + 5'h01;
                // low byte chosen once op and index bits are in; the status bit on the pin stays
                if (bitCount == 5'd7)
                    shiftOut <= {shiftOut[15], respByte, 7'h00};
            end else if (!link.selN && sclkFall && bitCount != 5'h00) begin
                shiftOut <= {shiftOut[14:0], 1'b0};
            end
        end
    end

    assign link.miso = shiftOut[15];

    // ----------------------------------------------------------------
    // register bank and side effects
    // ----------------------------------------------------------------
    for (genvar g = 0; g < REG_COUNT; g++) begin : gBank
        always_ff @(posedge clk_sys) begin
            if (!nrst)
                regContent[g] <= REG_RESET_VALUE;
            else if (clkEn && applyWrite && !linBlocked && applyIdx == 5'(g))
                regContent[g] <= applyData;
        end
    end

    wire linSet   = linReq && linTxd;
    wire linClear = applyWrite && !linReq && (applyIdx == LIN_REG_INDEX);

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            flagClear    <= 1'b0;
            flagClearIdx <= 5'h00;
        end else if (clkEn) begin
            flagClear <= isFlagRd;
            if (isFlagRd)
                flagClearIdx <= index;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst)
            parityError <= 1'b0;
        else if (clkEn && isWrite)
            parityError <= parityBad;
    end

    // parking wins over a flush, so a second stalled write is not lost
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            pendingValid <= 1'b0;
            pendingFrame <= 16'h0000;
        end else if (clkEn) begin
            if (parkNow) begin
                pendingValid <= 1'b1;
                pendingFrame <= shiftIn;
            end else if (flushPend) begin
                pendingValid <= 1'b0;
            end
        end
    end

    // a blocked mode request leaves the mode as it was
    always_ff @(posedge clk_sys) begin
        if (!nrst)
            linTxRxMode <= 1'b0;
        else if (clkEn && linSet)
            linTxRxMode <= 1'b1;
        else if (clkEn && linClear)
            linTxRxMode <= 1'b0;
    end
endmodule : scf_device
`default_nettype wire

/* logic/scf_master.sv */
// scf_master: master end; sends one 16-bit frame per request
// assumes: device end samples on rising sclk; clk_sys 10 MHz
`default_nettype none
module scf_master (
    input  wire logic          clk_sys,
    input  wire logic          nrst,
    input  wire logic          clkEn,
    scf_link_if.master         link,
    input  wire logic          reqValid,
    input  wire logic [15:0]   reqFrame,
    input  wire logic          autoRead,
    output logic               reqReady,
    output logic               rspValid,
    output logic [15:0]        rspFrame
);
    import scf_pkg::*;

    // phase is two bits wide and lowCount saturates at 255
    if (HALF_BIT_CYCLES < 1 || 2 * HALF_BIT_CYCLES > 4) begin : gBadHalfBit
        $error("half bit length out of range");
    end
    if (SELECT_LOW_CYCLES > 254) begin : gBadSelectLow
        $error("select low time too long for counter");
    end

    typedef enum {IDLE, LEAD, SHIFT, HOLD} scf_mstate_type;
    scf_mstate_type state;
    logic [15:0] txShift;
    logic [15:0] rxShift;
    logic [4:0]  bitsLeft;
    logic [7:0]  lowCount;
    logic [1:0]  phase;
    logic        needRead;
    logic        sclkQ;

    // reads force bit 8 high
    wire [15:0] fixedReq = (reqFrame[15:14] == OP_WRITE) ? reqFrame : (reqFrame | 16'h0100);
    // only a due automatic read holds requests back; without it the user owes the read
    wire        autoDue  = needRead && autoRead;
    wire        takeReq  = (state == IDLE) && reqValid && !autoDue;
    wire        takeAuto = (state == IDLE) && autoDue;
    wire [15:0] nextTx   = takeAuto ? HARMLESS_READ : fixedReq;
    wire        longDone = lowCount >= 8'(SELECT_LOW_CYCLES);

    assign reqReady   = (state == IDLE) && !autoDue;
    assign link.selN  = (state == IDLE);
    assign link.sclk  = sclkQ;
    assign link.mosi  = txShift[15];

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            state    <= IDLE;
            txShift  <= 16'h0000;
            rxShift  <= 16'h0000;
            bitsLeft <= 5'h00;
            lowCount <= 8'h00;
            phase    <= 2'b00;
            needRead <= 1'b0;
            sclkQ    <= 1'b0;
            rspValid <= 1'b0;
            rspFrame <= 16'h0000;
        end else if (clkEn) begin
            rspValid <= 1'b0;
            if (state != IDLE && lowCount != 8'hFF)
                lowCount <= lowCount + 8'h01;
            unique case (state)
                IDLE: if (takeReq || takeAuto) begin
                    txShift  <= nextTx;
                    bitsLeft <= 5'(FRAME_BITS);
                    lowCount <= 8'h00;
                    phase    <= 2'b00;
                    needRead <= (nextTx[15:14] == OP_WRITE);
                    state    <= LEAD;
                end
                LEAD: state <= SHIFT;
                SHIFT: begin
                    phase <= phase + 2'b01;
                    if (phase == 2'(HALF_BIT_CYCLES - 1)) begin
                        sclkQ   <= 1'b1;
                        rxShift <= {rxShift[14:0], link.miso};
                    end else if (phase == 2'(2 * HALF_BIT_CYCLES - 1)) begin
                        sclkQ    <= 1'b0;
                        txShift  <= {txShift[14:0], 1'b0};
                        bitsLeft <= bitsLeft - 5'h01;
                        if (bitsLeft == 5'h01)
                            state <= HOLD;
                    end
                end
                HOLD: if (longDone) begin
                    rspValid <= 1'b1;
                    rspFrame <= rxShift;
                    state    <= IDLE;
                end
            endcase
        end
    end
endmodule : scf_master
`default_nettype wire

/* testbench/scf_link_assertions.sv */
// scf_link_assertions: wire checks on the frame link
// assumes: instantiated in tb beside the link, one clock
`default_nettype none
module scf_link_assertions (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic clkEn,
    input wire logic selN,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic miso
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] lowCnt;
    logic [4:0]  edgeCnt;
    logic [15:0] bits;
    // ----------------------------------------------------------------
    // frame bookkeeping
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!nrst || selN) begin
            lowCnt  <= 16'h0000;
            edgeCnt <= 5'h00;
        end else begin
            lowCnt  <= lowCnt + 16'h0001;
            edgeCnt <= edgeCnt + {4'h0, $rose(sclk)};
        end
    end
    // bits kept across deselect so the frame end can be judged
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            bits <= 16'h0000;
        end else if ($rose(sclk)) begin
            bits <= {bits[14:0], mosi};
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    // a low enable freezes both ends, stretching any phase
    default disable iff (!nrst || !clkEn);
    idle_clock_a: assert property (selN |-> !sclk)
        else $error("sclk moved while deselected");
    select_hold_a: assert property ($rose(selN) |-> lowCnt > 16'h0037)
        else $error("select low too short");
    bit_count_a: assert property ($rose(selN) |-> edgeCnt == 5'h10)
        else $error("frame not sixteen bits");
    lead_time_a: assert property ($fell(selN) |-> !sclk [*2])
        else $error("lead time too short");
    high_phase_a: assert property ($rose(sclk) |=> sclk ##1 !sclk)
        else $error("sclk high phase wrong");
    low_phase_a: assert property ($fell(sclk) |=> !sclk)
        else $error("sclk low phase short");
    mosi_steady_a: assert property ($rose(sclk) |=> $stable(mosi))
        else $error("mosi changed while sampled");
    read_next_a: assert property ($rose(selN) && bits[15] == bits[14] |-> bits[8])
        else $error("read without next bit");
    cover property ($rose(selN) && bits[15:14] == 2'b01);
    cover property ($rose(selN) && bits[15:14] == 2'b11);
    cover property ($rose(sclk) && miso);
endmodule : scf_link_assertions
`default_nettype wire

/* testbench/tb.sv */
// tb: master requests and device inputs driven here, replies judged
// assumes: master and device joined by one scf_link_if on clk_sys
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import scf_pkg::*;
    logic        clk_sys = 1'b0;
    logic        nrst = 1'b0;
    logic        reqValid = 1'b0, autoRead = 1'b0, parityEnable = 1'b0, linTxd = 1'b0, writeStall = 1'b0;
    logic [15:0] reqFrame = 16'h0000;
    logic        clkEn = 1'b1;
    logic [15:0] rspFrame, got;
    logic        reqReady, rspValid, flagClear, parityError, linTxRxMode;
    logic [4:0]  flagClearIdx;
    logic [4:0]  clrIdx = 5'h1F;
    logic [7:0]  fixedStatus = 8'hA6;
    logic [7:0]  extStatus = 8'h5C;
    logic [7:0]  flagsIn [REG_COUNT];
    logic [7:0]  regContent [REG_COUNT];
    int          n_errors = 0;
    int          checks = 0;
    scf_link_if link ();
    scf_master scf_master_i (.clk_sys(clk_sys), .nrst(nrst), .clkEn(clkEn), .link(link.master), .reqValid(reqValid),
        .reqFrame(reqFrame), .autoRead(autoRead), .reqReady(reqReady), .rspValid(rspValid), .rspFrame(rspFrame));
    scf_device scf_device_i (.clk_sys(clk_sys), .nrst(nrst), .clkEn(clkEn), .link(link.device),
        .fixedStatus(fixedStatus), .extStatus(extStatus), .flagsIn(flagsIn), .parityEnable(parityEnable),
        .linTxd(linTxd), .writeStall(writeStall), .regContent(regContent), .flagClearIdx(flagClearIdx),
        .flagClear(flagClear), .parityError(parityError), .linTxRxMode(linTxRxMode));
    scf_link_assertions scf_link_assertions_i (.clk_sys(clk_sys), .nrst(nrst), .clkEn(clkEn), .selN(link.selN),
        .sclk(link.sclk), .mosi(link.mosi), .miso(link.miso));
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    always #50 clk_sys = ~clk_sys;
    always @(negedge clk_sys) if (flagClear === 1'b1) clrIdx = flagClearIdx;
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic finish_test;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test
    // register effects land a cycle after select rises, hence the settle
    task automatic wait_rsp;
        int n;
        n = 0;
        @(negedge clk_sys);
        while (rspValid !== 1'b1 && n < 300) begin
            @(negedge clk_sys);
            n++;
        end
        got = rspFrame;
        if (n == 300) chk("response", 16'h0000, 16'hFFFF);
        repeat (3) @(negedge clk_sys);
    endtask : wait_rsp
    task automatic send(input logic [15:0] f);
        int n;
        n = 0;
        @(posedge clk_sys);
        reqValid <= 1'b1;
        reqFrame <= f;
        @(negedge clk_sys);
        while (reqReady !== 1'b1 && n < 300) begin
            @(negedge clk_sys);
            n++;
        end
        if (n == 300) chk("request taken", 16'h0001, 16'h0000);
        @(posedge clk_sys);
        reqValid <= 1'b0;
        wait_rsp();
    endtask : send
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_write_read;
        send(16'h42A5);
        chk("write reply", {fixedStatus, extStatus}, got);
        send(16'h0300);
        chk("read reply", {fixedStatus, 8'hA5}, got);
        chk("bank 1", 16'h00A5, {8'h00, regContent[1]});
    endtask : t_write_read
    task automatic t_flags;
        send(16'hC500);
        chk("flag reply", {fixedStatus, flagsIn[2]}, got);
        chk("flag clear index", 16'h0002, {11'h000, clrIdx});
    endtask : t_flags
    task automatic t_reserved;
        send(16'h865A);
        send(16'h0700);
        chk("reserved ignored", {fixedStatus, 8'h00}, got);
    endtask : t_reserved
    // 0x4801 has odd ones outside bit 8, so bit 8 must be 1 for even parity
    task automatic t_parity;
        @(posedge clk_sys);
        parityEnable <= 1'b1;
        send(16'h4801);
        send(16'h0900);
        chk("bad parity", {fixedStatus, 8'h00}, got);
        chk("parity error", 16'h0001, {15'h0000, parityError});
        send(16'h4901);
        send(16'h0900);
        chk("good parity", {fixedStatus, 8'h01}, got);
        chk("parity error clear", 16'h0000, {15'h0000, parityError});
        @(posedge clk_sys);
        parityEnable <= 1'b0;
    endtask : t_parity
    task automatic t_lin(input logic txd);
        @(posedge clk_sys);
        linTxd   <= txd;
        autoRead <= 1'b1;
        send(16'h66C0);
        wait_rsp();
        chk("auto read", {fixedStatus, 8'h00}, got);
        chk("lin mode", {15'h0000, txd}, {15'h0000, linTxRxMode});
        chk("lin reg", txd ? 16'h00C0 : 16'h0000, {8'h00, regContent[19]});
    endtask : t_lin
    task automatic t_park;
        @(posedge clk_sys);
        autoRead   <= 1'b0;
        writeStall <= 1'b1;
        send(16'h4A33);
        chk("parked", 16'h0000, {8'h00, regContent[5]});
        send(16'h0300);
        chk("stalled read", {fixedStatus, 8'hA5}, got);
        chk("park done", 16'h0033, {8'h00, regContent[5]});
        @(posedge clk_sys);
        writeStall <= 1'b0;
    endtask : t_park
    // both ends freeze together, so a frame stretched by a low enable still arrives intact
    task automatic t_freeze;
        fork
            send(16'h0300);
            begin
                repeat (30) @(posedge clk_sys);
                clkEn <= 1'b0;
                repeat (20) @(posedge clk_sys);
                clkEn <= 1'b1;
            end
        join
        chk("frozen read", {fixedStatus, 8'hA5}, got);
    endtask : t_freeze
    initial begin
        foreach (flagsIn[i]) flagsIn[i] = 8'hC3 ^ 8'(i);
        repeat (12) @(posedge clk_sys);
        nrst <= 1'b1;
        t_write_read();
        t_flags();
        t_reserved();
        t_parity();
        t_lin(1'b0);
        t_lin(1'b1);
        t_park();
        t_freeze();
        finish_test();
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        finish_test();
    end
endmodule : tb
`default_nettype wire
